/* File: logic/csi_stack_irq.sv */
// stack pointer, pointer registers and interrupt entry/return sequencing
// assumes instr_done marks each instruction boundary and is never raised
// together with a stack_op; data memory answers a read one cycle later
//
// Function
// - registers 26 to 31 pair into three 16-bit data pointers
// - pointer access uses displacement, post-increment or pre-decrement
// - stack grows down; push decrements by one, pop increments by one
// - calls and interrupt entry push return address, pointer minus two
// - returns pop the return address, stack pointer plus two
// - stack pointer always marks the next free byte, one below the top of stack
// - stack pointer held as high and low byte, read-write in i/o
// - core runs on the undivided clock and overlaps fetch with execute
// - register operands read and result written within one cycle
// - reset and every interrupt own a vector at low program addresses
// - lower vector address wins; reset first, then external interrupt zero
// - vector select moves vectors to boot start; fuse moves reset
// - interrupt taken only with own enable and global enable set
// - programmed boot lock bits suppress interrupts by program region
// - entry clears global enable; interrupt return sets it
// - taking a flag interrupt clears its flag; writing one clears too
// - disabled flags stay pending and are served later by priority
// - level requests serve only while present, no latched flag
// - one instruction runs after interrupt return before the next entry
// - status register is neither saved nor restored on entry/return
// - global disable acts at once, even against a same-cycle request
// - after global enable the next instruction runs before any entry
// - global interrupt enable is bit 7 of the status register
// - entry takes four cycles pushing the return address
// - interrupt return takes four cycles and sets global enable
`timescale 1ns/1ps
module csi_stack_irq (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // i/o space access
  input  wire logic [5:0]  io_addr,
  input  wire logic        io_we,
  input  wire logic        io_re,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // instruction sequencing
  input  wire logic        instr_done,
  input  wire logic        instr_is_sei,
  input  wire logic        instr_is_cli,
  input  wire logic [2:0]  stack_op,
  input  wire logic [7:0]  push_data,
  input  wire logic [11:0] pc_cur,
  input  wire logic [11:0] pc_next,
  // pointer registers
  input  wire logic        gpr_we,
  input  wire logic [2:0]  gpr_idx,
  input  wire logic [7:0]  gpr_wdata,
  input  wire logic        ptr_req,
  input  wire logic [1:0]  ptr_sel,
  input  wire logic [1:0]  ptr_mode,
  input  wire logic [5:0]  ptr_disp,
  output logic      [15:0] ptr_addr,
  output logic      [7:0]  gpr_rdata,
  // data memory
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_we,
  output logic             mem_re,
  input  wire logic [7:0]  mem_rdata,
  // interrupt requests and configuration pins
  input  wire logic [3:0]  irq_event,
  input  wire logic [3:0]  irq_level,
  input  wire logic        app_lock_bit,
  input  wire logic        boot_lock_bit,
  input  wire logic        reset_vector_fuse,
  // towards fetch
  output logic             stack_busy,
  output logic             irq_take,
  output logic      [11:0] irq_vector,
  output logic             ret_valid,
  output logic      [11:0] ret_pc,
  output logic      [11:0] reset_vector,
  output logic      [15:0] stack_pointer,
  output logic      [7:0]  status_register
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  csi_pkg::csi_seq_t seq_r;
  logic              pop_r;
  logic              entry_r;
  logic              interrupt_return_instr_r;
  logic [11:0]       pc_hold_r;
  logic [3:0]        pc_hi_r;
  logic [7:0]        gic_r;
  logic [7:0]        ien_r;
  logic [2:0]        pin_m_r;
  logic [2:0]        pin_s_r;
  logic [15:0]       sp_nxt;
  logic [15:0]       ptr_addr_c;
  logic [7:0]        gpr_rdata_c;
  logic [3:0]        flags_w;
  logic              pend_any_w;
  logic [2:0]        pend_idx_w;
  logic              idle;
  logic              gie;
  logic              suppress;
  logic              take_now;
  logic              start_push;
  logic              start_pop;
  logic              one_push;
  logic              one_pop;
  logic              sp_dn;
  logic              sp_up;
  logic              io_sp_wr;
  logic [11:0]       vec_c;

  function automatic logic io_hit(input logic [5:0] a,
                                  input logic [5:0] off);
    return a == off;
  endfunction

  assign idle = (seq_r == csi_pkg::ST_IDLE);
  assign gie  = status_register[csi_pkg::GIE_BIT];

  // lock bits only count in the region that holds no vectors
  assign suppress =
    (pc_cur <  csi_pkg::BOOT_START && pin_s_r[0] &&
      gic_r[csi_pkg::VSEL_BIT]) ||
    (pc_cur >= csi_pkg::BOOT_START && pin_s_r[1] &&
      !gic_r[csi_pkg::VSEL_BIT]);

  // boundary only, so a return or multi-cycle op always completes first
  assign take_now = instr_done && idle && gie && pend_any_w &&
                    !suppress && !instr_is_cli;

  assign start_push = idle && (take_now || stack_op == csi_pkg::SOP_CALL);
  assign start_pop  = idle && !take_now &&
                      (stack_op == csi_pkg::SOP_RET ||
                       stack_op == csi_pkg::SOP_INTERRUPT_RETURN_INSTR);
  assign one_push   = idle && !take_now && stack_op == csi_pkg::SOP_PUSH;
  assign one_pop    = idle && !take_now && stack_op == csi_pkg::SOP_POP;
  assign sp_dn      = start_push || one_push ||
                      (seq_r == csi_pkg::ST_C1 && !pop_r);
  assign sp_up      = start_pop || one_pop ||
                      (seq_r == csi_pkg::ST_C1 && pop_r);
  assign io_sp_wr   = io_we && (io_hit(io_addr, csi_pkg::IO_SPL) ||
                                io_hit(io_addr, csi_pkg::IO_SPH));

  // vector 0 is reset, so source n sits n+1 steps above the base
  assign vec_c = (gic_r[csi_pkg::VSEL_BIT] ? csi_pkg::BOOT_START
                                           : 12'h000) +
                 12'({9'h000, pend_idx_w} * csi_pkg::VEC_STEP) +
                 csi_pkg::VEC_STEP;

  ////////////////////////////////////////////////////////////////////////////
  // submodules

  csi_ptr_file u_ptr (
    .clk       (clk),
    .arst_n    (arst_n),
    .gpr_we    (gpr_we),
    .gpr_idx   (gpr_idx),
    .gpr_wdata (gpr_wdata),
    .gpr_rdata (gpr_rdata_c),
    .ptr_req   (ptr_req),
    .ptr_sel   (ptr_sel),
    .ptr_mode  (ptr_mode),
    .ptr_disp  (ptr_disp),
    .ptr_addr  (ptr_addr_c)
  );

  csi_irq_arb u_arb (
    .clk        (clk),
    .arst_n     (arst_n),
    .irq_event  (irq_event),
    .irq_level  (irq_level),
    .irq_enable (ien_r),
    .flag_clear (io_we && io_hit(io_addr, csi_pkg::IO_IFLAG) ?
                 io_wdata[3:0] : 4'h0),
    .take       (take_now),
    .flags      (flags_w),
    .pend_any   (pend_any_w),
    .pend_idx   (pend_idx_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer

  always_comb
  begin
    sp_nxt = stack_pointer;
    if (io_we && io_hit(io_addr, csi_pkg::IO_SPL))
      sp_nxt = {stack_pointer[15:8], io_wdata};
    else if (io_we && io_hit(io_addr, csi_pkg::IO_SPH))
      sp_nxt = {io_wdata, stack_pointer[7:0]};
    else if (sp_dn)
      sp_nxt = stack_pointer - 16'h0001;
    else if (sp_up)
      sp_nxt = stack_pointer + 16'h0001;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      stack_pointer <= {csi_pkg::SPH_RST, csi_pkg::SPL_RST};
    else
      stack_pointer <= sp_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-byte sequencer: calls, returns and interrupt entry

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq_r      <= csi_pkg::ST_IDLE;
      pop_r      <= 1'b0;
      entry_r    <= 1'b0;
      interrupt_return_instr_r     <= 1'b0;
      pc_hold_r  <= 12'h000;
      pc_hi_r    <= 4'h0;
      stack_busy <= 1'b0;
      mem_we     <= 1'b0;
      mem_re     <= 1'b0;
      mem_addr   <= 16'h0000;
      mem_wdata  <= 8'h00;
      irq_take   <= 1'b0;
      irq_vector <= 12'h000;
      ret_valid  <= 1'b0;
      ret_pc     <= 12'h000;
    end
    else
    begin
      mem_we    <= 1'b0;
      mem_re    <= 1'b0;
      irq_take  <= 1'b0;
      ret_valid <= 1'b0;
      case (seq_r)
        csi_pkg::ST_IDLE:
        begin
          if (start_push || start_pop)
          begin
            seq_r      <= csi_pkg::ST_C1;
            stack_busy <= 1'b1;
            pop_r      <= start_pop;
            entry_r    <= take_now;
            interrupt_return_instr_r     <= (stack_op == csi_pkg::SOP_INTERRUPT_RETURN_INSTR);
            pc_hold_r  <= pc_next;
          end
          if (start_push || one_push)
          begin
            mem_we    <= 1'b1;
            mem_addr  <= stack_pointer;
            mem_wdata <= one_push ? push_data : pc_next[7:0];
          end
          if (start_pop || one_pop)
          begin
            mem_re   <= 1'b1;
            mem_addr <= stack_pointer + 16'h0001;
          end
          if (take_now)
            irq_vector <= vec_c;
        end
        csi_pkg::ST_C1:
        begin
          seq_r <= csi_pkg::ST_C2;
          if (pop_r)
          begin
            mem_re   <= 1'b1;
            mem_addr <= stack_pointer + 16'h0001;
          end
          else
          begin
            mem_we    <= 1'b1;
            mem_addr  <= stack_pointer;
            mem_wdata <= {4'h0, pc_hold_r[11:8]};
          end
        end
        csi_pkg::ST_C2:
        begin
          seq_r <= csi_pkg::ST_C3;
          if (pop_r)
            pc_hi_r <= mem_rdata[3:0];
        end
        csi_pkg::ST_C3:
        begin
          seq_r     <= csi_pkg::ST_C4;
          ret_pc    <= {pc_hi_r, mem_rdata};
          ret_valid <= pop_r;
          irq_take  <= entry_r;
        end
        default:
        begin
          seq_r      <= csi_pkg::ST_IDLE;
          stack_busy <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status, control and enable registers

  // only the enable bit is touched by entry and return
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      status_register <= csi_pkg::STATUS_REGISTER_RST;
    else
    begin
      if (io_we && io_hit(io_addr, csi_pkg::IO_STATUS_REGISTER))
        status_register <= io_wdata;
      if (instr_done && instr_is_sei)
        status_register[csi_pkg::GIE_BIT] <= 1'b1;
      if (instr_done && instr_is_cli)
        status_register[csi_pkg::GIE_BIT] <= 1'b0;
      if (take_now)
        status_register[csi_pkg::GIE_BIT] <= 1'b0;
      if (seq_r == csi_pkg::ST_C3 && pop_r && interrupt_return_instr_r)
        status_register[csi_pkg::GIE_BIT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gic_r <= csi_pkg::GIC_RST;
      ien_r <= csi_pkg::IEN_RST;
    end
    else
    begin
      if (io_we && io_hit(io_addr, csi_pkg::IO_GIC))
        gic_r <= io_wdata;
      if (io_we && io_hit(io_addr, csi_pkg::IO_IEN))
        ien_r <= io_wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      io_rdata <= 8'h00;
    else if (io_re)
      case (io_addr)
        csi_pkg::IO_SPL:   io_rdata <= stack_pointer[7:0];
        csi_pkg::IO_SPH:   io_rdata <= stack_pointer[15:8];
        csi_pkg::IO_STATUS_REGISTER:  io_rdata <= status_register;
        csi_pkg::IO_GIC:   io_rdata <= gic_r;
        csi_pkg::IO_IFLAG: io_rdata <= {4'h0, flags_w};
        csi_pkg::IO_IEN:   io_rdata <= ien_r;
        default:           io_rdata <= 8'h00;
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins, pointer outputs and reset vector

  // single undivided clock; fetch overlap lives in the outer pipeline
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_m_r      <= 3'h0;
      pin_s_r      <= 3'h0;
      reset_vector <= 12'h000;
      ptr_addr     <= 16'h0000;
      gpr_rdata    <= 8'h00;
    end
    else
    begin
      pin_m_r      <= {reset_vector_fuse, boot_lock_bit, app_lock_bit};
      pin_s_r      <= pin_m_r;
      reset_vector <= pin_s_r[2] ? csi_pkg::BOOT_START : 12'h000;
      ptr_addr     <= ptr_addr_c;
      gpr_rdata    <= gpr_rdata_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_push;
    @(posedge clk) disable iff (!arst_n)
    (one_push && !io_sp_wr) |=> stack_pointer == $past(stack_pointer) - 16'h0001;
  endproperty
  a_push: assert property (p_push)
    else $error("push did not lower the stack pointer by one");

  property p_call;
    @(posedge clk) disable iff (!arst_n)
    (start_push && !io_sp_wr) ##1 !io_sp_wr
      |=> stack_pointer == $past(stack_pointer, 2) - 16'h0002;
  endproperty
  a_call: assert property (p_call)
    else $error("call or entry did not lower the stack pointer by two");

  property p_ret;
    @(posedge clk) disable iff (!arst_n)
    (start_pop && !io_sp_wr) ##1 !io_sp_wr
      |=> stack_pointer == $past(stack_pointer, 2) + 16'h0002;
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not raise the stack pointer by two");

  property p_entry;
    @(posedge clk) disable iff (!arst_n)
    take_now |=> !gie ##3 (irq_take && irq_vector == $past(vec_c, 4));
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry did not clear enable or vector after four cycles");

  property p_interrupt_return_instr;
    @(posedge clk) disable iff (!arst_n)
    (start_pop && stack_op == csi_pkg::SOP_INTERRUPT_RETURN_INSTR) |-> ##4 (gie && ret_valid);
  endproperty
  a_interrupt_return_instr: assert property (p_interrupt_return_instr)
    else $error("interrupt return did not set enable in four cycles");

  property p_cli;
    @(posedge clk) disable iff (!arst_n)
    (instr_done && instr_is_cli && idle) |=> (!gie && idle);
  endproperty
  a_cli: assert property (p_cli)
    else $error("interrupt entered in the cycle of global disable");

  property p_gate;
    @(posedge clk) disable iff (!arst_n)
    (seq_r == csi_pkg::ST_C1 && entry_r) |-> $past(gie) && !gie;
  endproperty
  a_gate: assert property (p_gate)
    else $error("interrupt entered while global enable was clear");

endmodule // csi_stack_irq

/* File: common/csi_pkg.sv */
// constants and types shared by the stack and interrupt-entry block
// assumes one core clock and one asynchronous active-low reset
package csi_pkg;

  localparam int          PC_W        = 12;
  localparam logic [11:0] BOOT_START  = 12'hc00;
  localparam logic [11:0] VEC_STEP    = 12'h001;
  localparam int          ENTRY_CYC   = 4;
  localparam int          N_IRQ       = 8;
  localparam int          N_FLAG      = 4;
  localparam int          N_PTR       = 3;

  // i/o space offsets
  localparam logic [5:0]  IO_IEN      = 6'h39;
  localparam logic [5:0]  IO_IFLAG    = 6'h3a;
  localparam logic [5:0]  IO_GIC      = 6'h3b;
  localparam logic [5:0]  IO_SPL      = 6'h3d;
  localparam logic [5:0]  IO_SPH      = 6'h3e;
  localparam logic [5:0]  IO_STATUS_REGISTER     = 6'h3f;

  // values after reset
  localparam logic [7:0]  SPL_RST     = 8'h00;
  localparam logic [7:0]  SPH_RST     = 8'h00;
  localparam logic [7:0]  STATUS_REGISTER_RST    = 8'h00;
  localparam logic [7:0]  GIC_RST     = 8'h00;
  localparam logic [7:0]  IEN_RST     = 8'h00;
  localparam logic [15:0] PTR_RST     = 16'h0000;

  // field positions
  localparam int          GIE_BIT     = 7;
  localparam int          VSEL_BIT    = 1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_C1   = 3'b001,
    ST_C2   = 3'b011,
    ST_C3   = 3'b010,
    ST_C4   = 3'b110
  } csi_seq_t;

  typedef enum logic [2:0] {
    SOP_NONE = 3'h0,
    SOP_PUSH = 3'h1,
    SOP_POP  = 3'h2,
    SOP_CALL = 3'h3,
    SOP_RET  = 3'h4,
    SOP_INTERRUPT_RETURN_INSTR = 3'h5
  } csi_sop_t;

  typedef enum logic [1:0] {
    PM_PLAIN   = 2'h0,
    PM_DISP    = 2'h1,
    PM_POSTINC = 2'h2,
    PM_PREDEC  = 2'h3
  } csi_pmode_t;

endpackage

/* File: logic/csi_ptr_file.sv */
// the six upper working registers and their use as three 16-bit pointers
// assumes pointer select 3 is never issued; it is folded onto the third pair
`timescale 1ns/1ps
module csi_ptr_file (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // ordinary register access
  input  wire logic        gpr_we,
  input  wire logic [2:0]  gpr_idx,
  input  wire logic [7:0]  gpr_wdata,
  output logic      [7:0]  gpr_rdata,
  // pointer access
  input  wire logic        ptr_req,
  input  wire logic [1:0]  ptr_sel,
  input  wire logic [1:0]  ptr_mode,
  input  wire logic [5:0]  ptr_disp,
  output logic      [15:0] ptr_addr
);

  logic [47:0] pairs_w;
  logic [1:0]  sel_c;
  logic [15:0] base_c;
  logic [15:0] upd_c;
  logic        step_c;

  always_comb
  begin
    sel_c  = (ptr_sel == 2'h3) ? 2'h2 : ptr_sel;
    base_c = pairs_w[{sel_c, 4'h0} +: 16];
    step_c = ptr_req && (ptr_mode == csi_pkg::PM_POSTINC ||
                         ptr_mode == csi_pkg::PM_PREDEC);
    upd_c  = (ptr_mode == csi_pkg::PM_PREDEC) ? base_c - 16'h0001
                                              : base_c + 16'h0001;
    case (ptr_mode)
      csi_pkg::PM_DISP:   ptr_addr = base_c + {10'h000, ptr_disp};
      csi_pkg::PM_PREDEC: ptr_addr = base_c - 16'h0001;
      default:            ptr_addr = base_c;
    endcase
    gpr_rdata = (gpr_idx < 3'h6) ? pairs_w[{gpr_idx, 3'h0} +: 8] : 8'h00;
  end

  for (genvar g = 0; g < csi_pkg::N_PTR; g++)
  begin : g_pair
    logic [15:0] val_r;
    // the pointer step wins over a plain write to the same pair
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        val_r <= csi_pkg::PTR_RST;
      else if (step_c && sel_c == 2'(g))
        val_r <= upd_c;
      else if (gpr_we && gpr_idx == 3'(2 * g))
        val_r[7:0] <= gpr_wdata;
      else if (gpr_we && gpr_idx == 3'(2 * g + 1))
        val_r[15:8] <= gpr_wdata;
    end
    assign pairs_w[16 * g +: 16] = val_r;
  end

  property p_postinc;
    @(posedge clk) disable iff (!arst_n)
    (ptr_req && ptr_mode == csi_pkg::PM_POSTINC && sel_c == 2'h0)
      |=> pairs_w[15:0] == $past(base_c) + 16'h0001;
  endproperty
  a_postinc: assert property (p_postinc)
    else $error("pointer post-increment did not step by one");

endmodule // csi_ptr_file

/* File: logic/csi_irq_arb.sv */
// interrupt flags, level requests and fixed priority selection
// assumes events and levels come from logic on the same clock
`timescale 1ns/1ps
module csi_irq_arb (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // requests
  input  wire logic [3:0] irq_event,
  input  wire logic [3:0] irq_level,
  // control
  input  wire logic [7:0] irq_enable,
  input  wire logic [3:0] flag_clear,
  input  wire logic       take,
  // state
  output logic      [3:0] flags,
  output logic            pend_any,
  output logic      [2:0] pend_idx
);

  logic [7:0] pend_c;

  function automatic logic [2:0] first_set(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (v[i])
        r = 3'(i);
    return r;
  endfunction

  // levels carry no flag, so a vanished condition is never served
  assign pend_c   = {irq_level, flags} & irq_enable;
  assign pend_any = |pend_c;
  assign pend_idx = first_set(pend_c);

  for (genvar g = 0; g < csi_pkg::N_FLAG; g++)
  begin : g_flag
    // a new event wins over a clear in the same cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        flags[g] <= 1'b0;
      else if (irq_event[g])
        flags[g] <= 1'b1;
      else if (flag_clear[g] || (take && pend_idx == 3'(g)))
        flags[g] <= 1'b0;
    end
  end

  property p_prio;
    @(posedge clk) disable iff (!arst_n)
    pend_any |-> pend_c[pend_idx] &&
      ((pend_c & ((8'h01 << pend_idx) - 8'h01)) == 8'h00);
  endproperty
  a_prio: assert property (p_prio)
    else $error("selected request is not the lowest pending one");

  property p_hw_clear;
    @(posedge clk) disable iff (!arst_n)
    (take && pend_idx == 3'h0 && !irq_event[0]) |=> !flags[0];
  endproperty
  a_hw_clear: assert property (p_hw_clear)
    else $error("flag not cleared when its vector was taken");

  property p_keep;
    @(posedge clk) disable iff (!arst_n)
    (flags[1] && !take && flag_clear == 4'h0) |=> flags[1];
  endproperty
  a_keep: assert property (p_keep)
    else $error("pending flag lost without service or clear");

endmodule // csi_irq_arb

/* File: dv/csi_mem_model.sv */
// data memory on the far side of the stack block
// assumes one clock; a read answers in the cycle after mem_re
`timescale 1ns/1ps
module csi_mem_model (
  // clock
  input  wire logic        clk,
  // strobes from the stack block
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_we,
  input  wire logic        mem_re,
  // read return
  output logic      [7:0]  mem_rdata
);
  logic [7:0] m [0:65535];
  initial mem_rdata = 8'h00;
  // idle data toggles so a late sample never looks right
  always @(posedge clk)
  begin
    if (mem_we) m[mem_addr] <= mem_wdata;
    if (mem_re) mem_rdata <= m[mem_addr];
    else mem_rdata <= ~mem_rdata;
  end
endmodule // csi_mem_model

/* File: dv/tb.sv */
// self-checking bench for the stack and interrupt-entry block
// assumes csi_mem_model as data memory; lock pins stay unprogrammed
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0, arst_n = 1'b0;
  logic [5:0]  io_addr = 6'h00;
  logic        io_we = 1'b0, io_re = 1'b0, instr_done = 1'b0;
  logic        instr_is_sei = 1'b0, instr_is_cli = 1'b0;
  logic [2:0]  stack_op = 3'h0;
  logic [7:0]  io_wdata = 8'h00, push_data = 8'h00;
  logic [11:0] pc_cur = 12'h000, pc_next = 12'h000;
  logic [3:0]  irq_event = 4'h0, irq_level = 4'h0;
  logic [7:0]  io_rdata, mem_wdata, mem_rdata, status_register;
  logic [15:0] mem_addr, stack_pointer, s;
  logic        mem_we, mem_re, stack_busy, irq_take, ret_valid;
  logic [11:0] irq_vector, ret_pc, reset_vector;
  logic        gpr_we = 1'b0, ptr_req = 1'b0, reset_vector_fuse = 1'b0;
  logic [2:0]  gpr_idx = 3'h0;
  logic [1:0]  ptr_sel = 2'h0, ptr_mode = 2'h0;
  logic [5:0]  ptr_disp = 6'h00;
  logic [7:0]  gpr_wdata = 8'h00, gpr_rdata;
  logic [15:0] ptr_addr, p;
  int          fails = 0, tests_run = 0, cyc = 0, ntake = 0, n0 = 0;
  always #5 clk = ~clk;
  csi_stack_irq dut (.clk, .arst_n, .io_addr, .io_we, .io_re,
    .io_wdata, .io_rdata, .instr_done, .instr_is_sei, .instr_is_cli,
    .stack_op, .push_data, .pc_cur, .pc_next, .gpr_we, .gpr_idx,
    .gpr_wdata, .ptr_req, .ptr_sel, .ptr_mode, .ptr_disp, .ptr_addr,
    .gpr_rdata, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata,
    .irq_event, .irq_level, .app_lock_bit(1'b0), .boot_lock_bit(1'b0),
    .reset_vector_fuse, .stack_busy, .irq_take, .irq_vector,
    .ret_valid, .ret_pc, .reset_vector, .stack_pointer,
    .status_register);
  csi_mem_model mem (.clk, .mem_addr, .mem_wdata, .mem_we, .mem_re,
    .mem_rdata);
  ////////////////////////////////////////////////////////////////////
  task chk(input logic [15:0] v, input logic [15:0] e);
    tests_run++;
    if (v !== e)
    begin
      fails++;
      $display("MISMATCH %0t seen %h want %h", $time, v, e);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task io_w(input logic [5:0] a, input logic [7:0] d);
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(negedge clk);
    io_we = 1'b0;
    @(negedge clk);
  endtask
  task io_r(input logic [5:0] a);
    io_addr = a;
    io_re = 1'b1;
    @(negedge clk);
    io_re = 1'b0;
    @(negedge clk);
  endtask
  // waits out a two-byte sequence under a bound
  task settle;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 20 && stack_busy !== 1'b0; i++) @(negedge clk);
  endtask
  task step(input logic [2:0] o);
    stack_op = o;
    @(negedge clk);
    stack_op = 3'h0;
    settle();
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (irq_take === 1'b1) ntake <= ntake + 1;
    if (cyc == 3000)
    begin
      fails++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hd401));
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    io_r(csi_pkg::IO_SPH);
    chk(io_rdata, csi_pkg::SPH_RST);
    chk(status_register, csi_pkg::STATUS_REGISTER_RST);
    chk(reset_vector, 16'h0000);
    s = 16'h0200 | 16'($urandom & 32'hfe);
    io_w(csi_pkg::IO_SPL, s[7:0]);
    io_w(csi_pkg::IO_SPH, s[15:8]);
    io_r(csi_pkg::IO_SPL);
    chk(io_rdata, s[7:0]);
    push_data = 8'($urandom);
    step(csi_pkg::SOP_PUSH);
    chk(stack_pointer, s - 16'h1);
    chk(mem.m[s], push_data);
    step(csi_pkg::SOP_POP);
    chk(stack_pointer, s);
    pc_next = 12'($urandom);
    step(csi_pkg::SOP_CALL);
    chk(stack_pointer, s - 16'h2);
    chk({mem.m[s - 16'h1], mem.m[s]}, {4'h0, pc_next});
    step(csi_pkg::SOP_INTERRUPT_RETURN_INSTR);
    chk(stack_pointer, s);
    chk(ret_pc, pc_next);
    chk(status_register[7], 1'b1);
    $display("end of stack test");
    p = 16'($urandom);
    reset_vector_fuse = 1'b1;
    gpr_we = 1'b1;
    gpr_wdata = p[7:0];
    @(negedge clk);
    gpr_idx = 3'h1;
    gpr_wdata = p[15:8];
    @(negedge clk);
    gpr_we = 1'b0;
    ptr_disp = 6'($urandom);
    ptr_mode = csi_pkg::PM_DISP;
    ptr_req = 1'b1;
    @(negedge clk);
    chk(gpr_rdata, p[15:8]);
    chk(ptr_addr, p + {10'h000, ptr_disp});
    ptr_mode = csi_pkg::PM_POSTINC;
    @(negedge clk);
    chk(ptr_addr, p);
    ptr_mode = csi_pkg::PM_PREDEC;
    @(negedge clk);
    chk(ptr_addr, p);
    @(negedge clk);
    chk(ptr_addr, p - 16'h0001);
    ptr_req = 1'b0;
    chk(reset_vector, 16'(csi_pkg::BOOT_START));
    $display("end of pointer test");
    io_w(csi_pkg::IO_GIC, 8'h02);
    io_w(csi_pkg::IO_IEN, 8'h03);
    irq_event = 4'h3;
    @(negedge clk);
    irq_event = 4'h0;
    instr_done = 1'b1;
    @(negedge clk);
    instr_done = 1'b0;
    for (int i = 0; i < 10 && irq_take !== 1'b1; i++) @(negedge clk);
    chk(irq_vector, csi_pkg::BOOT_START + 12'h001);
    chk(status_register[7], 1'b0);
    settle();
    chk(stack_pointer, s - 16'h2);
    io_r(csi_pkg::IO_IFLAG);
    chk(io_rdata[3:0], 4'h2);
    step(csi_pkg::SOP_INTERRUPT_RETURN_INSTR);
    n0 = ntake;
    instr_done = 1'b1;
    instr_is_cli = 1'b1;
    @(negedge clk);
    instr_done = 1'b0;
    instr_is_cli = 1'b0;
    repeat (6) @(negedge clk);
    chk(16'(ntake - n0), 16'h0);
    chk(status_register[7], 1'b0);
    io_w(csi_pkg::IO_IFLAG, 8'h02);
    io_r(csi_pkg::IO_IFLAG);
    chk(io_rdata[3:0], 4'h0);
    io_w(csi_pkg::IO_GIC, 8'h00);
    io_w(csi_pkg::IO_IEN, 8'h10);
    irq_level = 4'h1;
    instr_done = 1'b1;
    instr_is_sei = 1'b1;
    @(negedge clk);
    instr_is_sei = 1'b0;
    @(negedge clk);
    instr_done = 1'b0;
    irq_level = 4'h0;
    for (int i = 0; i < 10 && irq_take !== 1'b1; i++) @(negedge clk);
    chk(irq_vector, 12'h005);
    settle();
    chk(stack_pointer, s - 16'h2);
    $display("end of interrupt test");
    finish_test();
  end
endmodule // tb
